// file: hw/exception_interrupt_control.sv
// Exception and interrupt delivery control with Wishbone register access
`timescale 1ns/1ps
`default_nettype none
`include "exc_map.svh"
module exception_interrupt_control #(
	parameter int AW = 32
) (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [7:0]         wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic      [31:0]        wb_dat_o,
	output logic                    wb_ack_o,
	input  wire logic               irq_pin_i,
	input  wire logic [7:0]         irq_vec_i,
	input  wire logic               nmi_pin_i,
	output logic                    irq_ack_o,
	input  wire logic [1:0]         current_privilege_level_i,
	input  wire logic               boundary_i,
	input  wire logic [AW-1:0]      cur_ip_i,
	input  wire logic [AW-1:0]      next_ip_i,
	input  wire logic               exc_valid_i,
	input  wire logic [7:0]         exc_vec_i,
	input  wire exc_pkg::exc_kind_t exc_kind_i,
	input  wire logic               dbg_trap_i,
	input  wire logic               stack_selector_move_i,
	input  wire logic               combined_stack_pointer_load_i,
	input  wire logic               handler_return_done_i,
	input  wire logic               task_state_update_done_i,
	input  wire logic               x87_op_i,
	input  wire logic [5:0]         x87_status_word_i,
	input  wire logic               simd_op_i,
	input  wire logic [5:0]         simd_flags_i,
	input  wire logic               align_cond_i,
	input  wire logic               fpu_absent_cond_i,
	input  wire logic               mcheck_cond_i,
	output logic                    take_o,
	output logic [7:0]              vec_o,
	output exc_pkg::exc_kind_t      kind_o,
	output logic [AW-1:0]           saved_instruction_pointer_o,
	output logic [AW-1:0]           desc_addr_o,
	output logic                    discard_o,
	output logic                    restartable_o,
	output logic                    simd_default_fix_o,
	output logic                    task_switch_en_o,
	output logic                    interrupt_enable_flag_o
);
	import exc_pkg::*;

	logic [1:0]    irq_s_q;
	logic [1:0]    nmi_s_q;
	logic [7:0]    vec_s1_q;
	logic [7:0]    vec_s2_q;
	logic          nmi_prev_q;
	logic          nmi_pend_q;
	logic          nmi_blk_q;
	logic          inhibit_q;
	logic          dbg_pend_q;
	logic [4:0]    ctrl_q;
	logic [13:0]   fpmask_q;
	logic [AW-1:0] tbase_q;
	logic          take_q;
	logic [7:0]    vec_q;
	exc_kind_t     kind_q;
	logic [AW-1:0] sip_q;
	logic          discard_q;
	logic          restart_q;
	logic          fix_q;
	logic          ack_q;
	logic [31:0]   rdat_q;
	logic          inh;
	logic          sel_v;
	logic [7:0]    sel_vec;
	exc_kind_t     sel_kind;
	logic          sel_nmi;
	logic          sel_intr;
	logic          sel_dbg;
	logic [5:0]    x87_live;
	logic [5:0]    simd_live;
	logic          wr;
	logic          rd;

	// Pin side synchronisers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_s_q  <= 2'h0;
			nmi_s_q  <= 2'h0;
			vec_s1_q <= 8'h00;
			vec_s2_q <= 8'h00;
		end else begin
			irq_s_q  <= {irq_s_q[0], irq_pin_i};
			nmi_s_q  <= {nmi_s_q[0], nmi_pin_i};
			vec_s1_q <= irq_vec_i;
			vec_s2_q <= vec_s1_q;
		end
	end

	assign inh = inhibit_q | combined_stack_pointer_load_i;
	assign x87_live  = x87_status_word_i & ~fpmask_q[5:0];
	assign simd_live = simd_flags_i & ~fpmask_q[`F_SIMD_LO +: 6];

	// Event selection at an instruction boundary, highest first
	always_comb begin
		sel_v    = 1'b0;
		sel_vec  = 8'h00;
		sel_kind = K_FAULT;
		sel_nmi  = 1'b0;
		sel_intr = 1'b0;
		sel_dbg  = 1'b0;
		if (boundary_i) begin
			if (mcheck_cond_i && !ctrl_q[`C_MC_DIS]) begin
				sel_v    = 1'b1;
				sel_vec  = `V_MC;
				sel_kind = K_ABORT;
			end else if (exc_valid_i) begin
				sel_v    = 1'b1;
				sel_vec  = exc_vec_i;
				sel_kind = exc_kind_i;
			end else if (fpu_absent_cond_i && !ctrl_q[`C_NM_DIS]) begin
				sel_v    = 1'b1;
				sel_vec  = `V_NM;
			end else if (align_cond_i && !ctrl_q[`C_AC_DIS]) begin
				sel_v    = 1'b1;
				sel_vec  = `V_AC;
			end else if (x87_op_i && |x87_live) begin
				sel_v    = 1'b1;
				sel_vec  = `V_MF;
			end else if (simd_op_i && |simd_live) begin
				sel_v    = 1'b1;
				sel_vec  = `V_XF;
			end else if ((dbg_trap_i || dbg_pend_q) && !inh) begin
				sel_v    = 1'b1;
				sel_vec  = `V_DEBUG;
				sel_kind = K_TRAP;
				sel_dbg  = 1'b1;
			end else if (nmi_pend_q && !nmi_blk_q && !inh) begin
				sel_v    = 1'b1;
				sel_vec  = `V_NMI;
				sel_kind = K_INTR;
				sel_nmi  = 1'b1;
			end else if (irq_s_q[1] && ctrl_q[`C_IE] && !inh) begin
				sel_v    = 1'b1;
				sel_vec  = vec_s2_q;
				sel_kind = K_INTR;
				sel_intr = 1'b1;
			end
		end
	end

	// NMI edge capture and nesting block
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nmi_prev_q <= 1'b0;
			nmi_pend_q <= 1'b0;
			nmi_blk_q  <= 1'b0;
		end else begin
			nmi_prev_q <= nmi_s_q[1];
			if (nmi_s_q[1] && !nmi_prev_q)
				nmi_pend_q <= 1'b1;
			else if (sel_nmi)
				nmi_pend_q <= 1'b0;
			// Set wins over a release in the same cycle
			if (sel_nmi)
				nmi_blk_q <= 1'b1;
			else if (handler_return_done_i || task_state_update_done_i)
				nmi_blk_q <= 1'b0;
		end
	end

	// Stack switch inhibit and deferred debug trap
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			inhibit_q  <= 1'b0;
			dbg_pend_q <= 1'b0;
		end else begin
			if (boundary_i)
				inhibit_q <= stack_selector_move_i;
			if (dbg_trap_i && !sel_dbg)
				dbg_pend_q <= 1'b1;
			else if (sel_dbg)
				dbg_pend_q <= 1'b0;
		end
	end

	// Delivery outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			take_q    <= 1'b0;
			vec_q     <= 8'h00;
			kind_q    <= K_FAULT;
			sip_q     <= '0;
			discard_q <= 1'b0;
			restart_q <= 1'b0;
			fix_q     <= 1'b0;
			irq_ack_o <= 1'b0;
		end else begin
			take_q    <= sel_v;
			irq_ack_o <= sel_intr;
			fix_q     <= boundary_i && simd_op_i && |simd_flags_i && !(|simd_live);
			if (sel_v) begin
				vec_q     <= sel_vec;
				kind_q    <= sel_kind;
				// Fault or abort points at the causer, others past it
				sip_q     <= (sel_kind == K_FAULT || sel_kind == K_ABORT) ? cur_ip_i : next_ip_i;
				discard_q <= (sel_kind == K_FAULT) || (sel_kind == K_ABORT);
				restart_q <= (sel_kind != K_ABORT);
			end
		end
	end

	assign take_o                      = take_q;
	assign vec_o                       = vec_q;
	assign kind_o                      = kind_q;
	assign saved_instruction_pointer_o = sip_q;
	assign desc_addr_o                 = tbase_q + AW'({vec_q, `ENTRY_SH'(0)});
	assign discard_o                   = discard_q;
	assign restartable_o               = restart_q;
	assign simd_default_fix_o          = fix_q;
	assign task_switch_en_o            = !ctrl_q[`C_LONG];
	assign interrupt_enable_flag_o     = ctrl_q[`C_IE];

	// Wishbone slave, one wait state
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
	assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q   <= `CTRL_RST;
			fpmask_q <= `FPMASK_RST;
			tbase_q  <= '0;
		end else if (wr && wb_sel_i[0]) begin
			unique case (wb_adr_i)
				`A_CTRL: begin
					ctrl_q[`C_IE]   <= wb_dat_i[`C_IE];
					ctrl_q[`C_LONG] <= wb_dat_i[`C_LONG];
					if (current_privilege_level_i == 2'h0)
						ctrl_q[4:2] <= wb_dat_i[4:2];
				end
				`A_FPMASK: fpmask_q[5:0] <= wb_dat_i[5:0];
				`A_TBASE: tbase_q[7:0] <= wb_dat_i[7:0];
				default: ;
			endcase
		end
		if (!rst_i && wr && wb_sel_i[1]) begin
			if (wb_adr_i == `A_FPMASK)
				fpmask_q[13:8] <= wb_dat_i[13:8];
			if (wb_adr_i == `A_TBASE)
				tbase_q[15:8] <= wb_dat_i[15:8];
		end
		if (!rst_i && wr && wb_adr_i == `A_TBASE && AW > 16) begin
			if (wb_sel_i[2])
				tbase_q[23:16] <= wb_dat_i[23:16];
			if (wb_sel_i[3])
				tbase_q[AW-1:24] <= wb_dat_i[AW-1:24];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0;
		end else begin
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
			if (rd) begin
				unique case (wb_adr_i)
					`A_CTRL:    rdat_q <= {27'h0, ctrl_q};
					`A_FPMASK:  rdat_q <= {18'h0, fpmask_q};
					`A_TBASE:   rdat_q <= 32'(tbase_q);
					`A_SAVEDIP: rdat_q <= 32'(sip_q);
					`A_STATUS:  rdat_q <= {20'h0, inhibit_q, restart_q, irq_s_q[1], nmi_blk_q, vec_q};
					default:    rdat_q <= 32'h0;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	intr_gated_ie_a: assert property (take_q && kind_q == K_INTR && vec_q != `V_NMI && !$past(nmi_pend_q)
		|-> $past(ctrl_q[`C_IE]) && !$past(inh)) else $error("interrupt taken while masked");
	nmi_hold_blk_a: assert property (nmi_blk_q && !handler_return_done_i && !task_state_update_done_i
		|=> nmi_blk_q) else $error("nmi block dropped early");
	nmi_no_nest_a: assert property (sel_nmi |-> !nmi_blk_q ##1 take_q && vec_q == `V_NMI && nmi_blk_q)
		else $error("nested nmi taken");
	fault_ip_a: assert property (sel_v && sel_kind == K_FAULT |=> sip_q == $past(cur_ip_i) && discard_q)
		else $error("fault pointer wrong");
	trap_ip_a: assert property (sel_v && sel_kind == K_TRAP |=> sip_q == $past(next_ip_i) && !discard_q)
		else $error("trap pointer wrong");
	abort_no_restart_a: assert property (take_q && kind_q == K_ABORT |-> !restart_q)
		else $error("abort marked restartable");
	table_index_a: assert property (take_q |-> desc_addr_o == tbase_q + AW'(vec_q) * AW'(16))
		else $error("descriptor address wrong");
	long_no_tsw_a: assert property (ctrl_q[`C_LONG] |-> !task_switch_en_o)
		else $error("task switch on in long mode");
	ss_inhibit_a: assert property (boundary_i && inhibit_q
		|-> !sel_nmi && !sel_intr && !sel_dbg) else $error("event inside stack inhibit");
	x87_vec_a: assert property (take_q && vec_q == `V_MF && kind_q != K_INTR && !$past(exc_valid_i)
		|-> $past(|x87_live)) else $error("masked x87 raised");
	wb_ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not single cycle");

	// Outcome of each event class
	abort_discard_a: assert property (take_q && kind_q == K_ABORT
		|-> discard_q)
		else $error("abort kept partial state");
	trap_keeps_a: assert property (take_q && kind_q == K_TRAP
		|-> !discard_q && restart_q)
		else $error("trap state dropped");
	fault_restart_a: assert property (take_q && kind_q == K_FAULT
		|-> restart_q && discard_q)
		else $error("fault not restartable");
	intr_next_ip_a: assert property (sel_intr
		|=> sip_q == $past(next_ip_i) && !discard_q)
		else $error("interrupt pointer wrong");
	abort_ip_a: assert property (sel_v && sel_kind == K_ABORT
		|=> sip_q == $past(cur_ip_i) && !restart_q)
		else $error("abort pointer wrong");

	// Delivery only at boundaries, state held between
	bnd_only_take_a: assert property (!boundary_i
		|=> !take_q)
		else $error("event off a boundary");
	sip_hold_a: assert property (!sel_v
		|=> $stable(sip_q))
		else $error("saved pointer moved");
	vec_kept_a: assert property (!sel_v
		|=> $stable(vec_q) && $stable(kind_q))
		else $error("vector moved without event");

	// Interrupt masking
	ie_mask_a: assert property (!ctrl_q[`C_IE]
		|-> !sel_intr)
		else $error("interrupt selected while masked");
	intr_ack_pair_a: assert property (irq_ack_o
		|-> take_q && kind_q == K_INTR)
		else $error("acknowledge without delivery");
	nmi_sets_blk_a: assert property (sel_nmi
		|=> nmi_blk_q)
		else $error("nmi block not set");
	load_inhibit_a: assert property (combined_stack_pointer_load_i
		|-> !sel_intr && !sel_nmi && !sel_dbg)
		else $error("event inside stack load");
	dbg_defer_a: assert property (dbg_trap_i && inh && !sel_dbg
		|=> dbg_pend_q)
		else $error("debug trap lost");

	// Disabled and masked conditions
	mc_taken_a: assert property (boundary_i && mcheck_cond_i && !ctrl_q[`C_MC_DIS]
		|=> take_q && vec_q == `V_MC && kind_q == K_ABORT)
		else $error("machine check not raised");
	mc_disabled_a: assert property (boundary_i && mcheck_cond_i && ctrl_q[`C_MC_DIS] && !exc_valid_i
		|-> sel_vec != `V_MC || sel_intr)
		else $error("disabled machine check raised");
	nm_disabled_a: assert property (boundary_i && fpu_absent_cond_i && ctrl_q[`C_NM_DIS] && !exc_valid_i
		|-> sel_vec != `V_NM || sel_intr)
		else $error("disabled unit-absent raised");
	ac_disabled_a: assert property (boundary_i && align_cond_i && ctrl_q[`C_AC_DIS] && !exc_valid_i
		|-> sel_vec != `V_AC || sel_intr)
		else $error("disabled alignment raised");
	simd_masked_a: assert property (boundary_i && simd_op_i && !(|simd_live) && !exc_valid_i
		|-> sel_vec != `V_XF || sel_intr)
		else $error("masked simd raised");
	mf_masked_a: assert property (boundary_i && x87_op_i && !(|x87_live) && !exc_valid_i
		|-> sel_vec != `V_MF || sel_intr)
		else $error("masked x87 selected");

endmodule : exception_interrupt_control
`default_nettype wire

// file: hw/exc_map.svh
// Offsets, field positions, reset values and vector numbers of the exception control block
// What this block does
// - Precise events are reported at the first uncompleted instruction boundary.
// - Return pointer to the reported boundary is saved automatically.
// - Imprecise events may hit any uncompleted instruction; program not restartable.
// - Reporting before the causer leaves no partial state from it.
// - Reporting after the causer keeps its state updates, task switch included.
// - Hardware task switching is off in long mode.
// - Faults discard instruction state and save pointer to the faulting instruction.
// - Traps complete the instruction and save pointer to the next one.
// - Aborts are imprecise and give no reliable restart point.
// - Maskable interrupts are taken only with enable flag 1, else held pending.
// - NMI ignores enable flag and blocks further NMI until return or task update.
// - Exception inside a return keeps NMI blocked until handler's own return.
// - After stack selector load, interrupts and debug wait one more instruction.
// - Combined stack pointer load inhibits interrupts until both parts are loaded.
// - Unmasked x87 exceptions raise vector 16.
// - Unmasked SIMD exceptions raise vector 19; masked ones get default handling.
// - Privileged software disables alignment, not-available and machine-check conditions.
// - Vector number indexes the descriptor table in every mode.
// - Only the return pointer is saved on handler entry.
// - Up to 256 vectors; lowest 32 reserved for predefined conditions.
`ifndef EXC_MAP_SVH
`define EXC_MAP_SVH
`define A_CTRL     8'h00
`define A_FPMASK   8'h04
`define A_TBASE    8'h08
`define A_SAVEDIP  8'h0c
`define A_STATUS   8'h10
`define C_IE       0
`define C_LONG     1
`define C_AC_DIS   2
`define C_NM_DIS   3
`define C_MC_DIS   4
`define F_SIMD_LO  8
`define CTRL_RST   5'h00
`define FPMASK_RST 14'h3f3f
`define V_DEBUG    8'h01
`define V_NMI      8'h02
`define V_NM       8'h07
`define V_MF       8'h10
`define V_AC       8'h11
`define V_MC       8'h12
`define V_XF       8'h13
`define V_NUM      256
`define V_RSVD     32
`define ENTRY_SH   4
`endif

// file: hw/exc_pkg.sv
// Types of the exception control block
package exc_pkg;
	typedef enum logic [1:0] {
		K_FAULT = 2'b00,
		K_TRAP  = 2'b01,
		K_ABORT = 2'b10,
		K_INTR  = 2'b11
	} exc_kind_t;
endpackage : exc_pkg

// file: tb/irq_source.sv
// External interrupt logic model driving the maskable and non-maskable lines
`timescale 1ns/1ps
`default_nettype none
module irq_source (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       fire_i,
	input  wire logic [7:0] vec_i,
	input  wire logic       nmi_fire_i,
	input  wire logic       ack_i,
	output logic            irq_pin_o,
	output logic [7:0]      irq_vec_o,
	output logic            nmi_pin_o
);
	logic [7:0] last_q;
	// Request held until acknowledged, independent of the core's instruction flow
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_pin_o <= 1'b0;
			last_q    <= 8'h00;
			nmi_pin_o <= 1'b0;
		end else begin
			if (fire_i) begin
				irq_pin_o <= 1'b1;
				last_q    <= vec_i;
			end else if (ack_i) begin
				irq_pin_o <= 1'b0;
			end
			nmi_pin_o <= nmi_fire_i;
		end
	end
	// Released vector lines show garbage, not the old vector
	assign irq_vec_o = irq_pin_o ? last_q : ~last_q;
endmodule : irq_source
`default_nettype wire

// file: tb/exception_interrupt_control_tb.sv
// Self-checking bench of the exception control block
`timescale 1ns/1ps
`default_nettype none
module exception_interrupt_control_tb;
	import exc_pkg::*;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_pin, nmi_pin, irq_ack_o, fire, nmi_fire;
	logic [7:0] wb_adr_i, irq_vec, fvec, exc_vec_i, vec_o;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, cur_ip_i, next_ip_i, sip, desc_addr_o, q;
	logic [1:0] current_privilege_level_i;
	logic boundary_i, exc_valid_i, ssm, hret, tsu, x87_op_i, simd_op_i, algn, fabs, mchk, take_o;
	logic discard_o, restartable_o, simd_fix, ts_en, ie_o;
	exc_kind_t exc_kind_i, kind_o;
	int error_cnt, n_tests;
	exception_interrupt_control #(.AW(32)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_pin_i(irq_pin), .irq_vec_i(irq_vec), .nmi_pin_i(nmi_pin),
		.irq_ack_o(irq_ack_o), .current_privilege_level_i(current_privilege_level_i), .boundary_i(boundary_i),
		.cur_ip_i(cur_ip_i), .next_ip_i(next_ip_i), .exc_valid_i(exc_valid_i), .exc_vec_i(exc_vec_i),
		.exc_kind_i(exc_kind_i), .dbg_trap_i(1'b0), .stack_selector_move_i(ssm),
		.combined_stack_pointer_load_i(1'b0), .handler_return_done_i(hret), .task_state_update_done_i(tsu),
		.x87_op_i(x87_op_i), .x87_status_word_i(6'h01), .simd_op_i(simd_op_i), .simd_flags_i(6'h01),
		.align_cond_i(algn), .fpu_absent_cond_i(fabs), .mcheck_cond_i(mchk), .take_o(take_o), .vec_o(vec_o),
		.kind_o(kind_o), .saved_instruction_pointer_o(sip), .desc_addr_o(desc_addr_o), .discard_o(discard_o),
		.restartable_o(restartable_o), .simd_default_fix_o(simd_fix), .task_switch_en_o(ts_en),
		.interrupt_enable_flag_o(ie_o));
	irq_source src_u (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .vec_i(fvec), .nmi_fire_i(nmi_fire),
		.ack_i(irq_ack_o), .irq_pin_o(irq_pin), .irq_vec_o(irq_vec), .nmi_pin_o(nmi_pin));
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task final_report;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : final_report
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'hf};
		do begin
			@(posedge clk_i);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 20);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
		if (i >= 20) begin
			error_cnt++;
			final_report();
		end
	endtask : wb
	// Flags: stack move, machine check, unit absent, alignment, SIMD, x87
	task bnd(input logic ex, input exc_kind_t k, input logic [7:0] v, input logic [5:0] f);
		@(posedge clk_i);
		{boundary_i, exc_valid_i, exc_kind_i, exc_vec_i} <= {1'b1, ex, k, v};
		{ssm, mchk, fabs, algn, simd_op_i, x87_op_i} <= f;
		@(posedge clk_i);
		{boundary_i, exc_valid_i, ssm, mchk, fabs, algn, simd_op_i, x87_op_i} <= 8'h00;
		#1;
	endtask : bnd
	task idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask : idle
	task reset_vals;
		wb(0, 8'h00, 0); chk(q, 32'h0);
		wb(0, 8'h04, 0); chk(q, 32'h3f3f);
		wb(0, 8'h20, 0); chk(q, 32'h0);
		chk(ts_en, 1'b1);
		chk(ie_o, 1'b0);
	endtask : reset_vals
	task core_exc;
		exc_kind_t k;
		wb(1, 8'h08, 32'h100);
		for (int i = 0; i < 3; i++) begin
			k = exc_kind_t'(i);
			bnd(1, k, 8'h0d, 6'h00);
			chk(take_o, 1'b1);
			chk(vec_o, 8'h0d);
			chk(kind_o, k);
			chk(sip, (k == K_TRAP) ? 32'h1004 : 32'h1000);
			chk(discard_o, k != K_TRAP);
			chk(restartable_o, k != K_ABORT);
			chk(desc_addr_o, 32'h100 + 32'hd0);
		end
	endtask : core_exc
	task maskable;
		@(posedge clk_i);
		{fire, fvec} <= {1'b1, 8'h41};
		@(posedge clk_i);
		fire <= 1'b0;
		idle(4);
		bnd(0, K_FAULT, 0, 6'h00); chk(take_o, 1'b0);
		bnd(0, K_FAULT, 0, 6'h20); chk(take_o, 1'b0);
		wb(1, 8'h00, 32'h1);
		bnd(0, K_FAULT, 0, 6'h00); chk(take_o, 1'b0);
		bnd(0, K_FAULT, 0, 6'h00);
		chk(take_o, 1'b1);
		chk(irq_ack_o, 1'b1);
		chk(vec_o, 8'h41);
		chk(kind_o, K_INTR);
		chk(sip, 32'h1004);
		idle(6);
	endtask : maskable
	task nmi_one(input logic e);
		@(posedge clk_i);
		nmi_fire <= 1'b1;
		@(posedge clk_i);
		nmi_fire <= 1'b0;
		idle(4);
		bnd(0, K_FAULT, 0, 6'h00);
		chk(take_o, e);
		if (e) chk(vec_o, 8'h02);
	endtask : nmi_one
	task nmi_seq;
		wb(1, 8'h00, 32'h0);
		nmi_one(1);
		nmi_one(0);
		@(posedge clk_i);
		hret <= 1'b1;
		@(posedge clk_i);
		hret <= 1'b0;
		bnd(0, K_FAULT, 0, 6'h00); chk(take_o, 1'b1);
		chk(vec_o, 8'h02);
		nmi_one(0);
		@(posedge clk_i);
		tsu <= 1'b1;
		@(posedge clk_i);
		tsu <= 1'b0;
		bnd(0, K_FAULT, 0, 6'h00); chk(take_o, 1'b1);
		chk(vec_o, 8'h02);
	endtask : nmi_seq
	task fp_and_disable;
		wb(1, 8'h04, 32'h3f00);
		bnd(0, K_FAULT, 0, 6'h01); chk(vec_o, 8'h10);
		bnd(0, K_FAULT, 0, 6'h02); chk(take_o, 1'b0);
		chk(simd_fix, 1'b1);
		wb(1, 8'h04, 32'h0);
		bnd(0, K_FAULT, 0, 6'h02); chk(vec_o, 8'h13);
		current_privilege_level_i <= 2'h3;
		wb(1, 8'h00, 32'h1c); wb(0, 8'h00, 0); chk(q, 32'h0);
		current_privilege_level_i <= 2'h0;
		wb(1, 8'h00, 32'h1c);
		bnd(0, K_FAULT, 0, 6'h04); chk(take_o, 1'b0);
		bnd(0, K_FAULT, 0, 6'h08); chk(take_o, 1'b0);
		wb(1, 8'h00, 32'h2);
		chk(ts_en, 1'b0);
		bnd(0, K_FAULT, 0, 6'h04); chk(vec_o, 8'h11);
		bnd(0, K_FAULT, 0, 6'h08); chk(vec_o, 8'h07);
		bnd(0, K_FAULT, 0, 6'h10); chk(vec_o, 8'h12);
	endtask : fp_and_disable
	initial begin
		error_cnt = 0;
		n_tests = 0;
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {4'b1000, 8'h00, 4'h0, 32'h0};
		{fire, fvec, nmi_fire, hret, current_privilege_level_i} = 12'h000;
		tsu = 1'b0;
		{boundary_i, exc_valid_i, exc_vec_i, exc_kind_i} = {10'h000, K_FAULT};
		{ssm, mchk, fabs, algn, simd_op_i, x87_op_i} = 6'h00;
		cur_ip_i = 32'h1000;
		next_ip_i = 32'h1004;
		idle(16);
		rst_i <= 1'b0;
		reset_vals();
		core_exc();
		maskable();
		nmi_seq();
		fp_and_disable();
		final_report();
	end
endmodule : exception_interrupt_control_tb
`default_nettype wire
